// ---- hw/lfd_pkg.sv ----
/*
  Shared constants for the LED fault-detect control block: register
  offsets, control field positions, reset values and grayscale counts.
  Assumes a 32-bit APB slave port with byte addresses and one word each.
*/
package lfd_pkg;
  // Register byte offsets
  localparam logic [7:0] CTRL_ADDR = 8'h00;
  localparam logic [7:0] STAT_ADDR = 8'h04;
  localparam logic [7:0] FAULT_ADDR = 8'h08;
  localparam logic [7:0] LEAK_ADDR = 8'h0C;
  // Control word field positions
  localparam int unsigned F_BLANK = 0;
  localparam int unsigned F_REPEAT = 1;
  localparam int unsigned F_DISPLAY_TIMING_RESET = 2;
  localparam int unsigned F_PWM_MODE = 3;
  localparam int unsigned F_OPEN_THR = 4;
  localparam int unsigned F_SHORT_THR = 6;
  localparam int unsigned F_LAT_TMG = 8;
  localparam int unsigned F_IDM_EN = 10;
  localparam int unsigned F_IDM_RPT = 11;
  localparam int unsigned F_IDM_CUR = 12;
  localparam int unsigned F_LEAK_EN = 14;
  localparam int unsigned F_PSAVE = 15;
  localparam int unsigned CTRL_W = 18;
  localparam logic [17:0] CTRL_RST = 18'h38001;
  // Status word field positions
  localparam int unsigned S_WRITTEN = 16;
  localparam int unsigned S_IDM_ACT = 17;
  localparam int unsigned S_PSAVE = 18;
  localparam int unsigned S_DONE = 19;
  // Channels and synchronised pins
  localparam int unsigned NCH = 16;
  localparam int unsigned SYNC_W = 51;
  // Grayscale counts
  localparam logic [15:0] GS_LAST = 16'hFFFF;
  localparam logic [15:0] LEAK_CAP_CNT = 16'hFFFE;
  localparam logic [7:0] LAT_HIT_17 = 8'h11;
  localparam logic [7:0] LAT_HIT_33 = 8'h21;
  localparam logic [7:0] LAT_HIT_65 = 8'h41;
  localparam logic [7:0] LAT_HIT_129 = 8'h81;
endpackage

// ---- hw/lfd_sync_if.sv ----
/*
  Carrier between the top module and its pin synchroniser: raw pin
  levels in, two-flop synchronised levels out.
  Assumes one clock domain on the synchroniser side.
*/
`timescale 1ns/100ps
`default_nettype none
interface lfd_sync_if #(parameter int unsigned W = 1);
  logic [W-1:0] raw;
  logic [W-1:0] sync;
  modport src (output raw, input sync);
  modport snk (input raw, output sync);
endinterface
`default_nettype wire

// ---- hw/lfd_sync.sv ----
/*
  Two-flop synchroniser bank for the asynchronous pins of the block.
  Assumes the raw levels may change at any time relative to clk_i.
*/
`timescale 1ns/100ps
`default_nettype none
module lfd_sync (
  input wire logic clk_i,   // Block clock
  input wire logic rst_b_i, // Async reset, active low
  lfd_sync_if.snk pins      // Raw in, synchronised out
);
  import lfd_pkg::*;
  logic [SYNC_W-1:0] meta_q;
  logic [SYNC_W-1:0] sync_q;

  // First flop feeds only the second one, never any logic
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= pins.raw;
      sync_q <= meta_q;
    end
  end

  assign pins.sync = sync_q;
endmodule
`default_nettype wire

// ---- hw/lfd_fault_ctl.sv ----
/*
  LED fault-detect control: function-control word behind an APB slave,
  grayscale-clock sequencing of invisible detection, open/short result
  latching, output leakage capture and power-save entry and exit.
  Assumes grayscale clock, latch strobe, serial clock and comparator
  results arrive as asynchronous pins much slower than MCLK_I, and that
  the grayscale-zero flags come from logic on MCLK_I.
*/
// Design decisions made here: the APB interface to the registers and the placing of the registers.
// Functional notes
// - Detection enable clear: open/short checked only at power-up, no sink current.
// - Detection enable set: small sink current during the detection segment.
// - Repeat clear: detect once after blank release, timing-reset latch or power-up.
// - Repeat set with auto repeat: detect every display period.
// - Detection enable clear keeps invisible detection off whatever repeat says.
// - Two-bit current select picks 2 uA, 10 uA, 20 uA or 1 mA sink.
// - Leakage enable clear: no leakage test, every leakage flag reads zero.
// - Leakage results captured on the 65,535th grayscale clock.
// - Leakage test only on outputs with zero grayscale; flag set when found.
// - Invisible detection enabled suppresses leakage detection.
// - Power-save select field resets to binary 111.
// - Open threshold select picks one of four thresholds, 0.3 V to 1.2 V.
// - Short threshold select picks one of four thresholds, 0.35 to 0.65 supply.
// - Results latched on 17th, 33rd, 65th or 129th grayscale clock after start.
// - Auto repeat without detect repeat: latch once per new grayscale write.
// - Detection bits reset to zero at power-on until software writes them.
// - Blank set forces outputs off, clears counter, initialises timing.
// - Auto repeat reruns the pattern every 65536 grayscale clocks.
// - Timing reset: grayscale latch clears counter, outputs off until next clock.
// - Power-save low bits both zero: never enter power save.
`timescale 1ns/100ps
`default_nettype none
module lfd_fault_ctl (
  input wire logic MCLK_I,                        // 20 MHz block clock
  input wire logic RST_B_I,                       // Async reset, active low
  input wire logic PSEL_I,                        // APB select
  input wire logic PENABLE_I,                     // APB access phase
  input wire logic PWRITE_I,                      // APB write
  input wire logic [7:0] PADDR_I,                 // APB byte address
  input wire logic [31:0] PWDATA_I,               // APB write data
  output logic [31:0] PRDATA_O,                   // APB read data
  output logic PREADY_O,                          // APB ready
  output logic PSLVERR_O,                         // APB error, unmapped
  input wire logic GRAYSCALE_CLOCK_I,             // Grayscale clock pin
  input wire logic LATCH_STROBE_I,                // Grayscale write latch
  input wire logic SERIAL_CLOCK_I,                // Serial shift clock pin
  input wire logic [lfd_pkg::NCH-1:0] OPEN_CMP_I, // Open comparators
  input wire logic [lfd_pkg::NCH-1:0] SHORT_CMP_I,// Short comparators
  input wire logic [lfd_pkg::NCH-1:0] LEAK_CMP_I, // Leakage comparators
  input wire logic [lfd_pkg::NCH-1:0] GS_ZERO_I,  // Grayscale value zero
  output logic OUT_ENABLE_O,                      // Outputs may switch on
  output logic [15:0] GS_COUNT_O,                 // Grayscale counter
  output logic IDM_SINK_O,                        // Inject detect sink
  output logic [1:0] IDM_CUR_SEL_O,               // Sink current code
  output logic [1:0] OPEN_THR_SEL_O,              // Open threshold code
  output logic [1:0] SHORT_THR_SEL_O,             // Short threshold code
  output logic [lfd_pkg::NCH-1:0] LEAK_TEST_O,    // Leak test per output
  output logic POWER_SAVE_O                       // Power-save state
);
  import lfd_pkg::*;

  // Latch-point count for the selected timing code
  function automatic logic [7:0] lat_hit(input logic [1:0] sel);
    logic [7:0] r;
    r = LAT_HIT_17;
    unique case (sel)
      2'h0: r = LAT_HIT_17;
      2'h1: r = LAT_HIT_33;
      2'h2: r = LAT_HIT_65;
      2'h3: r = LAT_HIT_129;
    endcase
    return r;
  endfunction

  // Synchronised pins
  lfd_sync_if #(.W(SYNC_W)) pins ();
  assign pins.raw = {LEAK_CMP_I, SHORT_CMP_I, OPEN_CMP_I,
                     SERIAL_CLOCK_I, LATCH_STROBE_I, GRAYSCALE_CLOCK_I};

  lfd_sync u_sync (
    .clk_i(MCLK_I),
    .rst_b_i(RST_B_I),
    .pins(pins.snk)
  );

  wire logic gclk_s = pins.sync[0];
  wire logic latch_s = pins.sync[1];
  wire logic sclk_s = pins.sync[2];
  wire logic [NCH-1:0] open_s = pins.sync[3 +: NCH];
  wire logic [NCH-1:0] short_s = pins.sync[3 + NCH +: NCH];
  wire logic [NCH-1:0] leak_s = pins.sync[3 + 2 * NCH +: NCH];

  // State
  logic [CTRL_W-1:0] ctrl_q;
  logic written_q;
  logic gclk_p_q, latch_p_q, sclk_p_q, blank_p_q;
  logic [15:0] gs_cnt_q, gs_cnt_d;
  logic done_q;
  logic force_off_q;
  logic [7:0] det_cnt_q;
  logic det_run_q;
  logic latch_ok_q;
  logic pwr_chk_q;
  logic gs_new_q;
  logic [NCH-1:0] open_q, short_q, leak_q;
  logic psave_q;
  logic [31:0] prdata_q;

  // Control fields
  wire logic blank = ctrl_q[F_BLANK];
  wire logic auto_display_repeat = ctrl_q[F_REPEAT];
  wire logic display_timing_reset = ctrl_q[F_DISPLAY_TIMING_RESET];
  wire logic [1:0] fault_latch_timing_sel = ctrl_q[F_LAT_TMG +: 2];
  wire logic invisible_detect_enable = ctrl_q[F_IDM_EN];
  wire logic invisible_detect_repeat = ctrl_q[F_IDM_RPT];
  wire logic leak_detect_enable = ctrl_q[F_LEAK_EN];
  wire logic [2:0] power_save_select = ctrl_q[F_PSAVE +: 3];

  // APB decode
  wire logic apb_setup = PSEL_I & ~PENABLE_I;
  wire logic apb_access = PSEL_I & PENABLE_I;
  wire logic hit_ctrl = PADDR_I == CTRL_ADDR;
  wire logic hit_stat = PADDR_I == STAT_ADDR;
  wire logic hit_fault = PADDR_I == FAULT_ADDR;
  wire logic hit_leak = PADDR_I == LEAK_ADDR;
  wire logic mapped = hit_ctrl | hit_stat | hit_fault | hit_leak;
  wire logic ctrl_wr = apb_access & PWRITE_I & hit_ctrl;

  // Pin events, seen on the synchronised copies only
  wire logic gclk_rise_raw = gclk_s & ~gclk_p_q;
  wire logic latch_rise = latch_s & ~latch_p_q;
  wire logic sclk_rise = sclk_s & ~sclk_p_q;
  wire logic blank_fall = blank_p_q & ~blank;

  // Bit 2 of the select stops the grayscale clock while saving power
  wire logic gclk_gate = psave_q & power_save_select[2];
  wire logic gclk_rise = gclk_rise_raw & ~gclk_gate;

  // Power save only with a nonzero low pair
  wire logic ps_allowed = power_save_select[1:0] != 2'h0;
  wire logic gs_all_zero = ~|GS_ZERO_I == 1'b0 ? &GS_ZERO_I : 1'b0;
  wire logic ps_enter = ps_allowed & latch_rise & gs_all_zero;
  wire logic ps_exit_sclk = power_save_select[1:0] == 2'h1 & sclk_rise;
  wire logic ps_exit_data = power_save_select[1] & latch_rise & ~gs_all_zero;

  // Start of a detection window
  wire logic tmg_latch = display_timing_reset & latch_rise & ~blank;
  wire logic at_last = gs_cnt_q == GS_LAST;
  wire logic wrap = gclk_rise & at_last & auto_display_repeat & ~blank;
  wire logic new_start = blank_fall | tmg_latch;

  // Latch point reached on this grayscale clock
  wire logic lat_point = gclk_rise & det_run_q & ~blank &
                         det_cnt_q == lat_hit(fault_latch_timing_sel) - 8'h01;

  // Who may latch: detection enable, or the one power-up check
  wire logic may_latch = invisible_detect_enable | pwr_chk_q;
  wire logic do_latch = lat_point & latch_ok_q & may_latch;

  // Leakage only when invisible detection is off
  wire logic leak_on = leak_detect_enable & ~invisible_detect_enable;
  wire logic leak_cap = gclk_rise & ~blank & gs_cnt_q == LEAK_CAP_CNT;

  // Repeat policy at a period wrap
  wire logic rpt_idm = invisible_detect_enable & invisible_detect_repeat;

  // Counter next value: blank holds it at zero
  always_comb begin
    gs_cnt_d = gs_cnt_q;
    if (blank || tmg_latch) begin
      gs_cnt_d = 16'h0000;
    end else if (gclk_rise && !done_q && !(at_last && !auto_display_repeat)) begin
      // Single period holds the count at its last value instead of wrapping
      gs_cnt_d = gs_cnt_q + 16'h0001;
    end
  end

  // Control word write; reset values only for blank and power save
  always_ff @(posedge MCLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      ctrl_q <= CTRL_RST;
      written_q <= 1'b0;
    end else if (ctrl_wr) begin
      ctrl_q <= PWDATA_I[CTRL_W-1:0];
      written_q <= 1'b1;
    end
  end

  // Edge history of pins and blank
  always_ff @(posedge MCLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      gclk_p_q <= 1'b0;
      latch_p_q <= 1'b0;
      sclk_p_q <= 1'b0;
      blank_p_q <= 1'b1;
    end else begin
      gclk_p_q <= gclk_s;
      latch_p_q <= latch_s;
      sclk_p_q <= sclk_s;
      blank_p_q <= blank;
    end
  end

  // Grayscale counter and end of a single display period
  always_ff @(posedge MCLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      gs_cnt_q <= 16'h0000;
      done_q <= 1'b0;
    end else begin
      gs_cnt_q <= gs_cnt_d;
      if (blank || new_start) begin
        done_q <= 1'b0;
      end else if (gclk_rise && at_last && !auto_display_repeat) begin
        done_q <= 1'b1;
      end
    end
  end

  // Forced off from a timing-reset latch until the next grayscale clock
  always_ff @(posedge MCLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      force_off_q <= 1'b0;
    end else if (tmg_latch) begin
      force_off_q <= 1'b1;
    end else if (gclk_rise) begin
      force_off_q <= 1'b0;
    end
  end

  // Detection window counter; blank reinitialises the timing
  always_ff @(posedge MCLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      det_cnt_q <= 8'h00;
      det_run_q <= 1'b0;
    end else if (blank) begin
      det_cnt_q <= 8'h00;
      det_run_q <= 1'b0;
    end else if (new_start || wrap) begin
      det_cnt_q <= 8'h00;
      det_run_q <= 1'b1;
    end else if (lat_point) begin
      det_run_q <= 1'b0;
    end else if (gclk_rise && det_run_q) begin
      det_cnt_q <= det_cnt_q + 8'h01;
    end
  end

  // Whether the current window may load the fault latch
  always_ff @(posedge MCLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      latch_ok_q <= 1'b0;
    end else if (new_start) begin
      latch_ok_q <= 1'b1;
    end else if (wrap) begin
      latch_ok_q <= rpt_idm | gs_new_q;
    end else if (lat_point) begin
      latch_ok_q <= 1'b0;
    end
  end

  // One check after power-up even with detection disabled
  always_ff @(posedge MCLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      pwr_chk_q <= 1'b1;
    end else if (lat_point && latch_ok_q) begin
      pwr_chk_q <= 1'b0;
    end
  end

  // New grayscale data marker; a new write wins over the clear
  always_ff @(posedge MCLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      gs_new_q <= 1'b0;
    end else if (latch_rise) begin
      gs_new_q <= 1'b1;
    end else if (do_latch) begin
      gs_new_q <= 1'b0;
    end
  end

  // Open and short result latch
  always_ff @(posedge MCLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      open_q <= '0;
      short_q <= '0;
    end else if (do_latch) begin
      open_q <= open_s;
      short_q <= short_s;
    end
  end

  // Leakage latch; flags zero while leakage detection is off
  always_ff @(posedge MCLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      leak_q <= '0;
    end else if (!leak_on) begin
      leak_q <= '0;
    end else if (leak_cap) begin
      leak_q <= leak_s & GS_ZERO_I;
    end
  end

  // Power-save state
  always_ff @(posedge MCLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      psave_q <= 1'b0;
    end else if (!ps_allowed) begin
      psave_q <= 1'b0;
    end else if (ps_enter) begin
      psave_q <= 1'b1;
    end else if (ps_exit_sclk || ps_exit_data) begin
      psave_q <= 1'b0;
    end
  end

  // Read data captured in the setup phase, stable through access
  always_ff @(posedge MCLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      prdata_q <= 32'h0000_0000;
    end else if (apb_setup) begin
      prdata_q <= hit_ctrl ? {14'h0000, ctrl_q} :
                  hit_stat ? {12'h000, done_q, psave_q, IDM_SINK_O, written_q, gs_cnt_q} :
                  hit_fault ? {short_q, open_q} :
                  hit_leak ? {16'h0000, leak_q} : 32'h0000_0000;
    end
  end

  // Zero-wait slave; unmapped addresses answer with an error
  assign PREADY_O = 1'b1;
  assign PSLVERR_O = apb_access & ~mapped;
  assign PRDATA_O = prdata_q;

  // Outputs off under blank, timing reset, period end or power save
  assign OUT_ENABLE_O = ~blank & ~force_off_q & ~done_q & ~psave_q;
  assign GS_COUNT_O = gs_cnt_q;

  // Sink only while detection runs and is enabled
  assign IDM_SINK_O = invisible_detect_enable & det_run_q & latch_ok_q & ~blank;
  assign IDM_CUR_SEL_O = ctrl_q[F_IDM_CUR +: 2];
  assign OPEN_THR_SEL_O = ctrl_q[F_OPEN_THR +: 2];
  assign SHORT_THR_SEL_O = ctrl_q[F_SHORT_THR +: 2];
  assign LEAK_TEST_O = leak_on ? GS_ZERO_I : '0;
  assign POWER_SAVE_O = psave_q;
endmodule
`default_nettype wire

// ---- tb/lfd_fault_ctl_properties.sv ----
/*
  Port checker for the fault-detect control block, with a mirror of the
  control word so gating can be judged from outside.
  Assumes it is bound into lfd_fault_ctl and shares its clock and reset.
*/
`timescale 1ns/100ps
`default_nettype none
module lfd_fault_ctl_properties (
  input wire logic MCLK_I, RST_B_I, PSEL_I, PENABLE_I, PWRITE_I, // Clock, reset, APB
  input wire logic [7:0] PADDR_I, // Byte address
  input wire logic [31:0] PWDATA_I, PRDATA_O, // Bus data
  input wire logic PREADY_O, PSLVERR_O, OUT_ENABLE_O, IDM_SINK_O, POWER_SAVE_O, // Flags
  input wire logic [1:0] IDM_CUR_SEL_O, OPEN_THR_SEL_O, SHORT_THR_SEL_O, // Codes
  input wire logic [15:0] GS_COUNT_O, // Counter
  input wire logic [lfd_pkg::NCH-1:0] GS_ZERO_I, LEAK_TEST_O // Leak gating
);
  import lfd_pkg::*;
  logic [CTRL_W-1:0] ctrl_q;
  // Access decode
  wire logic acc_w = PSEL_I && PENABLE_I;
  wire logic unmapped_w = PADDR_I[1:0] != 2'h0 || PADDR_I > LEAK_ADDR;
  wire logic ctrl_wr_w = acc_w && PWRITE_I && PADDR_I == CTRL_ADDR;
  // Mirror only; it follows the bus, not the design's register
  always_ff @(posedge MCLK_I or negedge RST_B_I) begin
    if (!RST_B_I)
      ctrl_q <= CTRL_RST;
    else if (ctrl_wr_w)
      ctrl_q <= PWDATA_I[CTRL_W-1:0];
  end
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (!RST_B_I);
  slverr_map_a: assert property (PSLVERR_O == (acc_w && unmapped_w)) else $error("error flag wrong");
  unmapped_zero_a: assert property (acc_w && !PWRITE_I && unmapped_w |-> PRDATA_O == 32'h0)
    else $error("unmapped read not zero");
  ctrl_readback_a: assert property (acc_w && !PWRITE_I && PADDR_I == CTRL_ADDR |->
    PRDATA_O == {14'h0, ctrl_q}) else $error("control readback wrong");
  sel_pass_a: assert property ({IDM_CUR_SEL_O, SHORT_THR_SEL_O, OPEN_THR_SEL_O} ==
    {ctrl_q[13:12], ctrl_q[7:6], ctrl_q[5:4]}) else $error("select codes wrong");
  no_sink_a: assert property (!ctrl_q[F_IDM_EN] |-> !IDM_SINK_O) else $error("sink while off");
  leak_off_a: assert property (!ctrl_q[F_LEAK_EN] || ctrl_q[F_IDM_EN] |-> LEAK_TEST_O == '0)
    else $error("leak test not gated");
  leak_pass_a: assert property (ctrl_q[F_LEAK_EN] && !ctrl_q[F_IDM_EN] |-> LEAK_TEST_O == GS_ZERO_I)
    else $error("leak test wrong outputs");
  blank_off_a: assert property (ctrl_q[0] && $past(ctrl_q[0]) && $past(ctrl_q[0], 2) |->
    !OUT_ENABLE_O && GS_COUNT_O == 16'h0) else $error("blank not honoured");
  count_step_a: assert property ($changed(GS_COUNT_O) |-> GS_COUNT_O == 16'h0 ||
    GS_COUNT_O == $past(GS_COUNT_O) + 16'h1) else $error("counter jumped");
  psave_never_a: assert property (ctrl_q[16:15] == 2'h0 && $past(ctrl_q[16:15]) == 2'h0 |->
    !POWER_SAVE_O) else $error("power save with select 00");
endmodule
bind lfd_fault_ctl lfd_fault_ctl_properties u_lfd_fault_ctl_properties (.MCLK_I(MCLK_I), .RST_B_I(RST_B_I),
  .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I),
  .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .OUT_ENABLE_O(OUT_ENABLE_O),
  .IDM_SINK_O(IDM_SINK_O), .POWER_SAVE_O(POWER_SAVE_O), .IDM_CUR_SEL_O(IDM_CUR_SEL_O),
  .OPEN_THR_SEL_O(OPEN_THR_SEL_O), .SHORT_THR_SEL_O(SHORT_THR_SEL_O), .GS_COUNT_O(GS_COUNT_O),
  .GS_ZERO_I(GS_ZERO_I), .LEAK_TEST_O(LEAK_TEST_O));
`default_nettype wire

// ---- tb/lfd_ctrl_model.sv ----
/*
  Display controller side: grayscale clock, latch strobe and serial clock pins.
  Assumes the block clock is much faster; pins stand still low between calls.
*/
`timescale 1ns/100ps
`default_nettype none
module lfd_ctrl_model (
  input wire logic clk_i, // Block clock
  output logic gclk_o, // Grayscale clock pin
  output logic lat_o, // Latch strobe pin
  output logic sclk_o // Serial clock pin
);
  initial gclk_o = 1'b0;
  initial lat_o = 1'b0;
  initial sclk_o = 1'b0;
  // Three clocks a level: the pin synchroniser needs at least two
  task automatic pulse(input int unsigned sel, input int unsigned n);
    for (int unsigned i = 0; i < 2 * n; i++) begin
      repeat (3) @(posedge clk_i);
      if (sel == 0)
        gclk_o <= ~gclk_o;
      else if (sel == 1)
        lat_o <= ~lat_o;
      else
        sclk_o <= ~sclk_o;
    end
    repeat (3) @(posedge clk_i);
  endtask
endmodule
`default_nettype wire

// ---- tb/tb_lfd_fault_ctl.sv ----
/*
  Testbench for the fault-detect control block: APB master, queued read checks.
  Assumes lfd_ctrl_model drives the pins; the checker is bound in.
*/
`timescale 1ns/100ps
`default_nettype none
module tb_lfd_fault_ctl;
  import lfd_pkg::*;
  logic mclk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, fault_v;
  logic pready, pslverr, out_en, sink, psave, gclk, lat, sclk;
  logic [1:0] cur_sel, open_sel, short_sel;
  logic [15:0] gs_count;
  logic [NCH-1:0] open_cmp = '0, short_cmp = '0, leak_cmp = '0, gs_zero = '0, leak_test;
  logic [31:0] exp_q[$];
  int n_errors = 0;
  int samples_checked = 0;
  int seed = 22742;
  always #25 mclk = ~mclk;
  lfd_fault_ctl u_lfd_fault_ctl (.MCLK_I(mclk), .RST_B_I(rst_b), .PSEL_I(psel), .PENABLE_I(penable),
    .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
    .PSLVERR_O(pslverr), .GRAYSCALE_CLOCK_I(gclk), .LATCH_STROBE_I(lat), .SERIAL_CLOCK_I(sclk),
    .OPEN_CMP_I(open_cmp), .SHORT_CMP_I(short_cmp), .LEAK_CMP_I(leak_cmp), .GS_ZERO_I(gs_zero),
    .OUT_ENABLE_O(out_en), .GS_COUNT_O(gs_count), .IDM_SINK_O(sink), .IDM_CUR_SEL_O(cur_sel),
    .OPEN_THR_SEL_O(open_sel), .SHORT_THR_SEL_O(short_sel), .LEAK_TEST_O(leak_test), .POWER_SAVE_O(psave));
  lfd_ctrl_model u_lfd_ctrl_model (.clk_i(mclk), .gclk_o(gclk), .lat_o(lat), .sclk_o(sclk));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("checks=%0d errors=%0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // One APB transfer; held until ready is seen at a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge mclk);
      if (pready === 1'b1)
        break;
    end
    if (i == 20) begin
      n_errors++;
      report_and_stop();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask
  // Control word: f is {leak, repeat, detect, blank}, s is {current, short, open}
  function automatic logic [31:0] cw(input logic [3:0] f, input logic [1:0] t, input logic [2:0] ps,
                                     input logic [5:0] s);
    logic [31:0] w;
    w = 32'h0;
    w[F_BLANK] = f[0];
    w[F_IDM_EN] = f[1];
    w[F_IDM_RPT] = f[2];
    w[F_LEAK_EN] = f[3];
    w[F_LAT_TMG +: 2] = t;
    w[F_PSAVE +: 3] = ps;
    w[F_OPEN_THR +: 4] = s[3:0];
    w[F_IDM_CUR +: 2] = s[5:4];
    return w;
  endfunction
  // Read data is compared at the edge that completes the access
  always @(posedge mclk) begin
    if (psel && penable && !pwrite && pready === 1'b1 && exp_q.size() > 0)
      check(prdata, exp_q.pop_front());
  end
  initial begin
    int unsigned n;
    repeat (20) @(posedge mclk);
    rst_b <= 1'b1;
    rd(CTRL_ADDR, 32'(CTRL_RST));
    check(32'(out_en), 32'h0);
    rd(8'h10, 32'h0);
    // Every threshold and current code reaches its output
    for (n = 0; n < 4; n++) begin
      wr_ctrl(cw(4'h1, 2'h0, 3'h7, {n[1:0], ~n[1:0], n[1:0]}));
      check({26'h0, cur_sel, short_sel, open_sel}, {26'h0, n[1:0], ~n[1:0], n[1:0]});
    end
    // Faults latch on the 17th, 33rd, 65th and 129th grayscale clock
    fault_v = 32'h0;
    for (n = 0; n < 4; n++) begin
      @(posedge mclk);
      open_cmp <= 16'($random(seed));
      short_cmp <= 16'($random(seed));
      leak_cmp <= 16'($random(seed));
      wr_ctrl(cw(4'h1, n[1:0], 3'h0, 6'h0));
      wr_ctrl(cw(4'h2, n[1:0], 3'h0, 6'h0));
      u_lfd_ctrl_model.pulse(0, 16 << n);
      rd(FAULT_ADDR, fault_v);
      u_lfd_ctrl_model.pulse(0, 1);
      fault_v = {short_cmp, open_cmp};
      rd(FAULT_ADDR, fault_v);
    end
    // Detection off with repeat set: no sink and no new results
    @(posedge mclk);
    open_cmp <= ~open_cmp;
    wr_ctrl(cw(4'h1, 2'h0, 3'h0, 6'h0));
    wr_ctrl(cw(4'h4, 2'h0, 3'h0, 6'h0));
    u_lfd_ctrl_model.pulse(0, 17);
    @(negedge mclk);
    check(32'(sink), 32'h0);
    rd(STAT_ADDR, 32'h0001_0011);
    rd(FAULT_ADDR, fault_v);
    // Leak test follows zero outputs only while effective
    @(posedge mclk);
    gs_zero <= 16'($random(seed));
    for (n = 0; n < 3; n++) begin
      wr_ctrl(cw(n == 0 ? 4'h9 : (n == 1 ? 4'hB : 4'h1), 2'h0, 3'h0, 6'h0));
      check(32'(leak_test), n == 0 ? 32'(gs_zero) : 32'h0);
    end
    // Select 00 never saves power; 10 leaves on data, 01 on serial clock
    for (n = 0; n < 3; n++) begin
      @(posedge mclk);
      gs_zero <= 16'hFFFF;
      wr_ctrl(cw(4'h1, 2'h0, 3'(n), 6'h0));
      u_lfd_ctrl_model.pulse(1, 1);
      check(32'(psave), n == 0 ? 32'h0 : 32'h1);
      gs_zero <= 16'h0001;
      u_lfd_ctrl_model.pulse(n == 1 ? 2 : 1, 1);
      check(32'(psave), 32'h0);
    end
    report_and_stop();
  end
  task automatic wr_ctrl(input logic [31:0] d);
    apb(1'b1, CTRL_ADDR, d);
    @(negedge mclk);
  endtask
  // Hang guard
  initial begin
    #1000000;
    n_errors++;
    report_and_stop();
  end
endmodule
`default_nettype wire
